/* verilog/sac_pkg.sv */
// sac_pkg: constants and types for the converter control block
// assumes a single 25 MHz core clock; times in ns are turned into cycles here
package sac_pkg;
  // ==========================================================================
  // widths and codes
  localparam int RES_W = 14;
  localparam logic [13:0] ABORT_CODE = 14'h3F80;
  localparam int FOLD_W = 6;
  localparam logic [2:0] INIT_CONVS = 3'h4;
  localparam int FIFO_DEPTH = 16;
  // ==========================================================================
  // timing
  localparam int CLK_NS = 40;
  localparam int CONV_NS = 273;
  localparam int RESET_PH_NS = 45;
  localparam int PWRDN_NS = 7200;
  localparam int CONV_CYC = CONV_NS / CLK_NS;
  localparam int RESET_PH_CYC = (RESET_PH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWRDN_CYC = (PWRDN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 9;
  // ==========================================================================
  // states
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b000,
    SAC_NAP = 3'b001,
    SAC_SAMPLE = 3'b010,
    SAC_CONV = 3'b011,
    SAC_RESET = 3'b100,
    SAC_PDOWN = 3'b101
  } sac_state_t;
endpackage : sac_pkg

/* verilog/sac_res_if.sv */
// sac_res_if: result stream between converter core and readout buffer
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface sac_res_if #(parameter int W = 14);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sac_res_if
`default_nettype wire

/* verilog/sac_fifo.sv */
// sac_fifo: flip-flop FIFO with valid/ready on both sides
// assumes a single clock; depth a power of two
`timescale 1ns/10ps
`default_nettype none
module sac_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  sac_res_if.snk in_s,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic full;
  logic push;
  logic pop;
  // ==========================================================================
  // flags
  assign full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign out_valid = (wr_ff != rd_ff);
  assign in_s.ready = !full;
  assign push = in_s.valid && !full;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ff[AW-1:0]];
  // ==========================================================================
  // storage and pointers
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_s.data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule : sac_fifo
`default_nettype wire

/* verilog/sac_readout.sv */
// sac_readout: drives the result bus from the latest result
// assumes result and controls synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module sac_readout
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [RES_W-1:0] result,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic byte_sel,
  output logic [RES_W-1:0] data_out,
  output logic data_oe
);
  // ==========================================================================
  // formatting, registered so the pins come from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      data_oe <= !chip_select_n && !read_n;
      if (byte_sel) begin
        data_out <= {result[FOLD_W-1:0], {(RES_W-FOLD_W){1'b0}}};
      end else begin
        data_out <= result;
      end
    end
  end
endmodule : sac_readout
`default_nettype wire

/* verilog/sac_conv_ctrl.sv */
// sac_conv_ctrl: sampling, conversion, abort, nap and reset control
// assumes all pins synchronous to core_clk; result value comes from analog side
`timescale 1ns/10ps
`default_nettype none
module sac_conv_ctrl
  import sac_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int PWRDN_CYCLES = PWRDN_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic powerdown_reset_n,
  input wire logic conv_start_strobe_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic byte_sel,
  input wire logic nap_enable_n,
  input wire logic [RES_W-1:0] analog_code,
  output logic busy,
  output logic napping,
  output logic powered_down,
  output logic in_reset,
  output logic result_invalid,
  output logic [RES_W-1:0] out_bus_data,
  output logic out_bus_oe,
  output logic stream_valid,
  input wire logic stream_ready,
  output logic [RES_W-1:0] stream_data
);
  sac_state_t state_ff;
  sac_state_t nxt_state;
  logic cs_q_ff;
  logic cv_q_ff;
  logic [CNT_W-1:0] conv_cnt_ff;
  logic [CNT_W-1:0] rst_cnt_ff;
  logic [2:0] init_cnt_ff;
  logic [RES_W-1:0] result_ff;
  logic cs_fall;
  logic cv_rise;
  logic cv_fall;
  logic conv_done;
  logic start_conv;
  logic abort;
  logic sample_start;
  sac_res_if #(.W(RES_W)) res_s ();

  // ==========================================================================
  // edge detection of host strobes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_q_ff <= 1'b1;
      cv_q_ff <= 1'b1;
    end else begin
      cs_q_ff <= chip_select_n;
      cv_q_ff <= conv_start_strobe_n;
    end
  end
  assign cs_fall = cs_q_ff && !chip_select_n;
  assign cv_rise = !cv_q_ff && conv_start_strobe_n;
  assign cv_fall = cv_q_ff && !conv_start_strobe_n;

  // ==========================================================================
  // decisions
  assign conv_done = (state_ff == SAC_CONV) && (conv_cnt_ff == CNT_W'(CONV_CYCLES - 1));
  // conversion triggers only from sampling, host keeps edges clean
  assign start_conv = (state_ff == SAC_SAMPLE)
    && ((cv_fall && !chip_select_n) || (cs_fall && !conv_start_strobe_n));
  assign abort = (state_ff == SAC_CONV) && cs_fall && conv_start_strobe_n;
  always_comb begin
    sample_start = 1'b0;
    if (state_ff == SAC_IDLE || state_ff == SAC_NAP) begin
      if (cv_rise && !chip_select_n) begin
        sample_start = 1'b1;
      end else if (cs_fall && conv_start_strobe_n) begin
        sample_start = 1'b1;
      end
    end
  end

  // ==========================================================================
  // state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SAC_IDLE, SAC_NAP: begin
        if (sample_start) begin
          nxt_state = SAC_SAMPLE;
        end else if (!nap_enable_n) begin
          nxt_state = SAC_NAP;
        end else begin
          nxt_state = SAC_IDLE;
        end
      end
      SAC_SAMPLE: begin
        if (start_conv) begin
          nxt_state = SAC_CONV;
        end
      end
      SAC_CONV: begin
        if (abort) begin
          nxt_state = SAC_IDLE;
        end else if (conv_done) begin
          // back-to-back: strobe held high, select low
          if (!chip_select_n && conv_start_strobe_n) begin
            nxt_state = SAC_SAMPLE;
          end else if (!nap_enable_n) begin
            nxt_state = SAC_NAP;
          end else begin
            nxt_state = SAC_IDLE;
          end
        end
      end
      SAC_RESET: begin
        if (powerdown_reset_n) begin
          nxt_state = SAC_IDLE;
        end else if (rst_cnt_ff >= CNT_W'(PWRDN_CYCLES)) begin
          nxt_state = SAC_PDOWN;
        end
      end
      SAC_PDOWN: begin
        if (powerdown_reset_n) begin
          nxt_state = SAC_IDLE;
        end
      end
      default: begin
        nxt_state = SAC_IDLE;
      end
    endcase
    // reset pin overrides all, aborting within one cycle
    if (!powerdown_reset_n && state_ff != SAC_RESET && state_ff != SAC_PDOWN) begin
      nxt_state = SAC_RESET;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= SAC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // conversion and reset timers; conversion time rounded down, power-down wait rounded up to whole cycles
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_cnt_ff <= '0;
    end else if (state_ff == SAC_CONV) begin
      conv_cnt_ff <= conv_cnt_ff + 1'b1;
    end else begin
      conv_cnt_ff <= '0;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_cnt_ff <= '0;
    end else if (state_ff == SAC_RESET) begin
      if (rst_cnt_ff != '1) begin
        rst_cnt_ff <= rst_cnt_ff + 1'b1;
      end
    end else begin
      rst_cnt_ff <= '0;
    end
  end

  // ==========================================================================
  // result and init counting
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_ff <= ABORT_CODE;
    end else if (state_ff == SAC_RESET || abort) begin
      result_ff <= ABORT_CODE;
    end else if (conv_done) begin
      result_ff <= analog_code;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      init_cnt_ff <= '0;
    end else if (state_ff == SAC_RESET || state_ff == SAC_PDOWN) begin
      init_cnt_ff <= '0;
    end else if (conv_done && init_cnt_ff != INIT_CONVS) begin
      init_cnt_ff <= init_cnt_ff + 1'b1;
    end
  end

  // ==========================================================================
  // status outputs
  assign busy = (state_ff == SAC_CONV);
  assign napping = (state_ff == SAC_NAP);
  assign powered_down = (state_ff == SAC_PDOWN);
  assign in_reset = (state_ff == SAC_RESET);
  assign result_invalid = (init_cnt_ff != INIT_CONVS);

  // ==========================================================================
  // result stream, only valid results; a full buffer drops new words
  assign res_s.valid = conv_done && !abort && (init_cnt_ff == INIT_CONVS);
  assign res_s.data = analog_code;

  sac_fifo #(
    .W(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .in_s(res_s.snk),
    .out_valid(stream_valid),
    .out_ready(stream_ready),
    .out_data(stream_data)
  );

  sac_readout u_readout (
    .clk(core_clk),
    .rst(rst),
    .result(result_ff),
    .chip_select_n(chip_select_n),
    .read_n(read_n),
    .byte_sel(byte_sel),
    .data_out(out_bus_data),
    .data_oe(out_bus_oe)
  );
endmodule : sac_conv_ctrl
`default_nettype wire

/* bench/sac_conv_ctrl_monitor.sv */
// port checks for the converter control block
// assumes the default 6-cycle conversion
`timescale 1ns/10ps
`default_nettype none
module sac_conv_ctrl_monitor
  import sac_pkg::*;
#(parameter int PWRDN_CYCLES = PWRDN_CYC) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic powerdown_reset_n,
  input wire logic conv_start_strobe_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic byte_sel,
  input wire logic nap_enable_n,
  input wire logic busy,
  input wire logic napping,
  input wire logic powered_down,
  input wire logic in_reset,
  input wire logic result_invalid,
  input wire logic [RES_W-1:0] out_bus_data,
  input wire logic out_bus_oe
);
  // ==========
  // helpers
  logic cs_ff;
  logic [3:0] bcnt_ff;
  logic [8:0] lcnt_ff;
  logic abort_ev;
  assign abort_ev = cs_ff && !chip_select_n && conv_start_strobe_n && busy;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_ff <= 1'b1;
      bcnt_ff <= 4'h0;
      lcnt_ff <= 9'h000;
    end else begin
      cs_ff <= chip_select_n;
      bcnt_ff <= busy ? bcnt_ff + 4'h1 : 4'h0;
      lcnt_ff <= powerdown_reset_n ? 9'h000 : lcnt_ff + 9'h001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========
  // properties
  property p_rise;
    $rose(busy) |-> ($past(conv_start_strobe_n, 2) && !$past(conv_start_strobe_n))
      || ($past(chip_select_n, 2) && !$past(chip_select_n));
  endproperty
  a_rise: assert property (p_rise) else $error("busy rose without trigger");
  property p_len;
    $fell(busy) |-> bcnt_ff == 4'h6 || $past(abort_ev) || !$past(powerdown_reset_n)
      || !$past(powerdown_reset_n, 2);
  endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_abort;
    abort_ev |=> !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("abort kept busy");
  property p_oe;
    1'b1 |-> out_bus_oe == (!$past(chip_select_n) && !$past(read_n));
  endproperty
  a_oe: assert property (p_oe) else $error("bus enable wrong");
  property p_fold;
    out_bus_oe && $past(byte_sel) |-> out_bus_data[7:0] == 8'h00;
  endproperty
  a_fold: assert property (p_fold) else $error("folded low lines not zero");
  property p_full;
    out_bus_oe && $past(out_bus_oe) && !$past(byte_sel) && $past(byte_sel, 2)
      && !$past(busy) && !$past(busy, 2) |-> out_bus_data[5:0] == $past(out_bus_data[13:8]);
  endproperty
  a_full: assert property (p_full) else $error("full word mismatch");
  property p_nap;
    napping |-> !busy && !$past(nap_enable_n);
  endproperty
  a_nap: assert property (p_nap) else $error("nap without enable");
  property p_rst;
    !powerdown_reset_n |=> in_reset || powered_down;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not entered");
  property p_pd;
    !powerdown_reset_n && lcnt_ff < PWRDN_CYCLES |-> !powered_down;
  endproperty
  a_pd: assert property (p_pd) else $error("early power-down");
  property p_inv;
    $fell(in_reset) |-> result_invalid;
  endproperty
  a_inv: assert property (p_inv) else $error("valid after reset");
endmodule : sac_conv_ctrl_monitor
bind sac_conv_ctrl sac_conv_ctrl_monitor #(.PWRDN_CYCLES(PWRDN_CYCLES)) u_mon (
  .core_clk(core_clk), .rst(rst), .powerdown_reset_n(powerdown_reset_n),
  .conv_start_strobe_n(conv_start_strobe_n), .chip_select_n(chip_select_n),
  .read_n(read_n), .byte_sel(byte_sel), .nap_enable_n(nap_enable_n), .busy(busy),
  .napping(napping), .powered_down(powered_down), .in_reset(in_reset),
  .result_invalid(result_invalid), .out_bus_data(out_bus_data), .out_bus_oe(out_bus_oe));
`default_nettype wire

/* bench/sac_host_model.sv */
// host side: one strobe-driven conversion per request
// assumes chip select held low by the bench
`timescale 1ns/10ps
`default_nettype none
module sac_host_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req,
  input wire logic busy,
  output logic strobe_n,
  output logic done
);
  // ==========
  // strobe sequencer
  logic [5:0] cnt_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 6'h00;
      strobe_n <= 1'b1;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cnt_ff == 6'h00) begin
        cnt_ff <= {5'h00, req};
      end else if ((cnt_ff > 6'h06 && !busy) || cnt_ff == 6'h3F) begin
        cnt_ff <= 6'h00;
        done <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 6'h01;
        // high for 3 cycles, covers the longer post-nap acquisition
        if (cnt_ff == 6'h02) strobe_n <= 1'b1;
        if (cnt_ff == 6'h01 || cnt_ff == 6'h05) strobe_n <= 1'b0;
      end
    end
  end
endmodule : sac_host_model
`default_nettype wire

/* bench/sac_conv_ctrl_test.sv */
// bench: random conversions, reads, buffer, abort, nap, reset
// assumes the monitor is bound to the design
`timescale 1ns/10ps
`default_nettype none
module sac_conv_ctrl_test
  import sac_pkg::*;
;
  logic core_clk, rst, pdr_n, hs_n, hi, cs_n, rd_n, bsel, nap_n, req, done;
  logic busy, napping, pdown, in_rst, inval, oe, sv, sr;
  logic [13:0] code, bus, sd, c;
  logic [13:0] q[$];
  integer seed = 79508;
  int bad_count, comparisons, i;
  sac_conv_ctrl #(.PWRDN_CYCLES(10)) dut (.core_clk(core_clk), .rst(rst),
    .powerdown_reset_n(pdr_n), .conv_start_strobe_n(hs_n | hi), .chip_select_n(cs_n),
    .read_n(rd_n), .byte_sel(bsel), .nap_enable_n(nap_n), .analog_code(code), .busy(busy),
    .napping(napping), .powered_down(pdown), .in_reset(in_rst), .result_invalid(inval),
    .out_bus_data(bus), .out_bus_oe(oe), .stream_valid(sv), .stream_ready(sr),
    .stream_data(sd));
  sac_host_model host (.core_clk(core_clk), .rst(rst), .req(req), .busy(busy),
    .strobe_n(hs_n), .done(done));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==========
  // tasks
  function automatic logic [13:0] fold(logic [13:0] v);
    return {v[5:0], 8'h00};
  endfunction : fold
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : step
  task automatic chk(string nm, logic [13:0] e, logic [13:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic conv(logic [13:0] v);
    int k;
    k = 0;
    code = v;
    req = 1'b1;
    step(1);
    req = 1'b0;
    while (!done && k < 40) begin
      step(1);
      k++;
    end
    if (!done) begin
      bad_count++;
      close_out;
    end
  endtask : conv
  task automatic rd(logic b, logic [13:0] e);
    bsel = b;
    rd_n = 1'b0;
    step(2);
    chk("bus", e, bus);
    rd_n = 1'b1;
    step(2);
    chk("bus off", 14'h0000, {13'h0000, oe});
  endtask : rd
  // ==========
  // sequence
  initial begin
    {rst, pdr_n, cs_n, rd_n, nap_n, sr} = 6'h3F;
    {hi, bsel, req, code, bad_count, comparisons} = 0;
    step(10);
    rst = 1'b0;
    step(1);
    cs_n = 1'b0;
    for (i = 0; i < 4; i++) begin
      chk("invalid", 14'h0001, {13'h0000, inval});
      conv(14'($random(seed)));
    end
    step(1);
    chk("valid", 14'h0000, {13'h0000, inval});
    $display("test init done");
    for (i = 0; i < 8; i++) begin
      c = 14'($random(seed));
      conv(c);
      rd(1'b0, c);
      rd(1'b1, fold(c));
    end
    $display("test read done");
    sr = 1'b0;
    for (i = 0; i < 18; i++) begin
      c = 14'($random(seed));
      if (i < 16) q.push_back(c);
      conv(c);
    end
    sr = 1'b1;
    for (i = 0; i < 16; i++) begin
      chk("fifo", q[i], sv ? sd : ~q[i]);
      step(1);
    end
    chk("fifo empty", 14'h0000, {13'h0000, sv});
    $display("test buffer done");
    req = 1'b1;
    step(1);
    req = 1'b0;
    step(8);
    chk("busy", 14'h0001, {13'h0000, busy});
    cs_n = 1'b1;
    hi = 1'b1;
    step(1);
    cs_n = 1'b0;
    step(2);
    chk("abort busy", 14'h0000, {13'h0000, busy});
    step(6);
    rd(1'b0, ABORT_CODE);
    hi = 1'b0;
    step(2);
    $display("test abort done");
    nap_n = 1'b0;
    conv(14'($random(seed)));
    chk("nap", 14'h0001, {13'h0000, napping});
    nap_n = 1'b1;
    step(2);
    chk("wake", 14'h0000, {13'h0000, napping});
    $display("test nap done");
    c = 14'($random(seed));
    code = c;
    req = 1'b1;
    step(1);
    req = 1'b0;
    step(8);
    hi = 1'b1;
    step(4);
    chk("b2b idle", 14'h0000, {13'h0000, busy});
    hi = 1'b0;
    step(2);
    chk("b2b busy", 14'h0001, {13'h0000, busy});
    step(8);
    bsel = 1'b1;
    rd_n = 1'b0;
    step(2);
    bsel = 1'b0;
    step(2);
    chk("b2b bus", c, bus);
    rd_n = 1'b1;
    step(2);
    $display("test back-to-back done");
    req = 1'b1;
    step(1);
    req = 1'b0;
    step(8);
    pdr_n = 1'b0;
    step(2);
    chk("reset busy", 14'h0000, {13'h0000, busy});
    chk("in reset", 14'h0001, {13'h0000, in_rst});
    rd(1'b0, ABORT_CODE);
    pdr_n = 1'b1;
    step(2);
    chk("invalid", 14'h0001, {13'h0000, inval});
    pdr_n = 1'b0;
    step(14);
    chk("pdown", 14'h0001, {13'h0000, pdown});
    pdr_n = 1'b1;
    step(3);
    $display("test reset done");
    close_out;
  end
endmodule : sac_conv_ctrl_test
`default_nettype wire
